// ==== tb/uss_line_model.sv ====
// Far side of the buffer: deserializer pulses and serializer ready.
// Assumes the bench calls put and quiet from its main sequence.
`timescale 1ns/1ns
module uss_line_model (
  input wire logic mclk,
  input wire logic reset,
  input wire logic hold,
  input wire logic slow,
  output uss_pkg::uss_char_type rx_uart_char,
  output uss_pkg::uss_char_type rx_ir_char,
  output logic tx_ready
);
  initial begin
    rx_uart_char = '0;
    rx_ir_char = '0;
    tx_ready = 1'b0;
  end
  // Slow mode toggles ready so a character waits one extra cycle
  always @(posedge mclk) begin
    tx_ready <= !reset && !hold && (!slow || !tx_ready);
  end
  task automatic put(input logic ir, input logic [7:0] d);
    @(posedge mclk);
    rx_ir_char <= '{valid: ir, data: ir ? d : ~rx_ir_char.data};
    rx_uart_char <= '{valid: !ir, data: ir ? ~rx_uart_char.data : d};
  endtask
  // Idle data lines flip so a stale byte never looks fresh
  task automatic quiet();
    @(posedge mclk);
    rx_ir_char <= '{valid: 1'b0, data: ~rx_ir_char.data};
    rx_uart_char <= '{valid: 1'b0, data: ~rx_uart_char.data};
  endtask
endmodule

// ==== tb/uss_shadow_buffer_tb_top.sv ====
// Self-checking bench for the shadow receive/transmit buffer.
// Assumes the line model on the far side; design assertions run alongside.
`timescale 1ns/1ns
`define USS_CHECK(got, exp, msg) begin checked++; if ((got) !== (exp)) begin bad_count++; \
  $display("CHECK FAILED %0t %s", $time, msg); end end
module uss_shadow_buffer_tb_top;
  localparam int D = 16;
  localparam logic [31:0] LS = uss_pkg::USS_LINE_STATUS;
  localparam logic [31:0] IS = uss_pkg::USS_INT_STATUS;
  localparam logic [31:0] AB = uss_pkg::USS_ALIAS_BASE;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic [31:0] reg_addr = 32'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic hold = 1'b0;
  logic slow = 1'b0;
  logic rd_seen = 1'b0;
  logic [31:0] reg_rdata;
  uss_pkg::uss_char_type rx_uart_char, rx_ir_char;
  uss_pkg::uss_tx_out_type tx_char;
  logic tx_ready, rx_data_available, tx_holding_empty, irq;
  logic [31:0] rq[$];
  logic [8:0] tq[$];
  logic [7:0] rxq[$];
  logic [31:0] seed = 32'h0001_668e;
  int bad_count = 0;
  int checked = 0;
  always #20 mclk = ~mclk;
  uss_shadow_buffer #(.DEPTH(D)) uss_shadow_buffer_i (.mclk(mclk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .rx_uart_char(rx_uart_char), .rx_ir_char(rx_ir_char), .tx_char(tx_char), .tx_ready(tx_ready),
    .rx_data_available(rx_data_available), .tx_holding_empty(tx_holding_empty), .irq(irq));
  uss_line_model uss_line_model_i (.mclk(mclk), .reset(reset), .hold(hold), .slow(slow),
    .rx_uart_char(rx_uart_char), .rx_ir_char(rx_ir_char), .tx_ready(tx_ready));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    {reg_write, reg_read} <= 2'b10;
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    @(posedge mclk);
    reg_addr <= a;
    {reg_write, reg_read} <= 2'b01;
    rq.push_back(e);
  endtask
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge mclk);
      {reg_write, reg_read} <= 2'b00;
    end
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic drain();
    for (int n = 0; n < 400 && tq.size() != 0; n++) @(posedge mclk);
    if (tq.size() != 0) begin
      bad_count++;
      $display("CHECK FAILED %0t transmit drain timeout", $time);
      end_of_test();
    end
  endtask
  // Answers are compared where they appear, against the oldest note
  always @(posedge mclk) begin
    if (rd_seen) `USS_CHECK(reg_rdata, (rq.size() != 0) ? rq.pop_front() : 32'hxxxx_xxxx, "read data")
    rd_seen <= reg_read && !reset;
    if (tx_char.valid === 1'b1 && tx_ready === 1'b1) begin
      `USS_CHECK({tx_char.ir, tx_char.data}, (tq.size() != 0) ? tq.pop_front() : 9'h1ff, "sent byte")
    end
  end
  initial begin
    repeat (10) @(posedge mclk);
    reset <= 1'b0;
    rd(LS, 32'h20);
    rd(uss_pkg::USS_CTRL, 32'h0);
    rd(32'h5000_1080, 32'h0);
    rd(IS, 32'h0);
    idle(2);
    $display("test reset done");
    wr(uss_pkg::USS_INT_MASK, 32'h1);
    idle(1);
    uss_line_model_i.put(1'b0, 8'h5a);
    uss_line_model_i.put(1'b0, 8'ha5);
    uss_line_model_i.quiet();
    repeat (2) @(negedge mclk);
    `USS_CHECK(irq, 1'b1, "interrupt not raised")
    rd(LS, 32'h23);
    rd(IS, 32'h3);
    rd(32'h5000_106c, 32'ha5);
    rd(LS, 32'h20);
    idle(3);
    @(negedge mclk);
    `USS_CHECK(irq, 1'b0, "interrupt not cleared")
    wr(uss_pkg::USS_INT_MASK, 32'h0);
    idle(1);
    uss_line_model_i.put(1'b0, 8'h3c);
    uss_line_model_i.quiet();
    repeat (3) @(negedge mclk);
    `USS_CHECK(irq, 1'b0, "masked interrupt raised")
    rd(uss_pkg::USS_SHADOW_BUFFER_1, 32'h3c);
    rd(IS, 32'h1);
    $display("test single receive done");
    wr(uss_pkg::USS_CTRL, 32'h2);
    idle(1);
    uss_line_model_i.put(1'b1, 8'h96);
    uss_line_model_i.put(1'b0, 8'h11);
    uss_line_model_i.quiet();
    rd(uss_pkg::USS_SHADOW_BUFFER_2, 32'h96);
    rd(LS, 32'h20);
    tq.push_back(9'h1c3);
    wr(AB, 32'hffff_ffc3);
    idle(1);
    drain();
    $display("test infrared done");
    wr(uss_pkg::USS_CTRL, 32'h0);
    hold <= 1'b1;
    tq.push_back(9'h041);
    tq.push_back(9'h043);
    wr(AB + 32'h4, 32'h41);
    idle(1);
    @(negedge mclk);
    `USS_CHECK(tx_holding_empty, 1'b0, "holding empty after write")
    idle(3);
    wr(AB + 32'h8, 32'h42);
    wr(AB + 32'hc, 32'h43);
    idle(1);
    @(negedge mclk);
    `USS_CHECK(tx_holding_empty, 1'b0, "holding not refilled")
    @(posedge mclk);
    hold <= 1'b0;
    drain();
    $display("test single transmit done");
    wr(uss_pkg::USS_CTRL, 32'h1);
    idle(1);
    for (int k = 0; k <= D; k++) begin
      seed = lfsr(seed);
      rxq.push_back(seed[7:0]);
      uss_line_model_i.put(1'b0, seed[7:0]);
    end
    uss_line_model_i.quiet();
    rd(LS, 32'h23);
    for (int k = 0; k < D; k++) rd(AB + 32'(4 * (k % 16)), {24'h0, rxq.pop_front()});
    idle(1);
    @(negedge mclk);
    `USS_CHECK(rx_data_available, 1'b0, "receive side not empty")
    rd(IS, 32'h7);
    idle(1);
    hold <= 1'b1;
    slow <= 1'b1;
    $display("test receive fifo done");
    for (int k = 0; k < D + 2; k++) begin
      seed = lfsr(seed);
      if (k < D + 1) tq.push_back({1'b0, seed[7:0]});
      wr(AB + 32'h3c, {24'h0, seed[7:0]});
      if (k == 0) idle(3);
    end
    rd(LS, 32'h40);
    rd(IS, 32'hc);
    idle(1);
    hold <= 1'b0;
    drain();
    rd(LS, 32'h20);
    idle(2);
    $display("test transmit fifo done");
    end_of_test();
  end
endmodule

// ==== verilog/uss_pkg.sv ====
// Package for the shadow receive/transmit buffer block.
// Assumes a 32-bit byte address on the plain register port.
package uss_pkg;
  localparam int unsigned USS_DEPTH = 16;
  localparam logic [31:0] USS_ALIAS_BASE = 32'h5000_1030;
  localparam int unsigned USS_ALIAS_COUNT = 16;
  localparam logic [31:0] USS_SHADOW_BUFFER_1 = 32'h5000_1034;
  localparam logic [31:0] USS_SHADOW_BUFFER_2 = 32'h5000_1038;
  localparam logic [31:0] USS_CTRL = 32'h5000_1070;
  localparam logic [31:0] USS_LINE_STATUS = 32'h5000_1074;
  localparam logic [31:0] USS_INT_STATUS = 32'h5000_1078;
  localparam logic [31:0] USS_INT_MASK = 32'h5000_107c;
  // Control fields
  localparam int unsigned USS_CTRL_FIFO_EN = 0;
  localparam int unsigned USS_CTRL_IR_MODE = 1;
  localparam logic [1:0] USS_CTRL_RESET = 2'h0;
  // Line status fields
  localparam int unsigned USS_LS_DATA_AVAIL = 0;
  localparam int unsigned USS_LS_OVERRUN = 1;
  localparam int unsigned USS_LS_TX_EMPTY = 5;
  localparam int unsigned USS_LS_TX_FULL = 6;
  // Interrupt status / mask fields
  localparam int unsigned USS_INT_RX = 0;
  localparam int unsigned USS_INT_OVERRUN = 1;
  localparam int unsigned USS_INT_TX_EMPTY = 2;
  localparam int unsigned USS_INT_TX_LOST = 3;
  localparam int unsigned USS_INT_BITS = 4;
  localparam logic [3:0] USS_INT_RESET = 4'h0;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } uss_char_type;

  typedef struct packed {
    logic valid;
    logic ir;
    logic [7:0] data;
  } uss_tx_out_type;
endpackage

// ==== verilog/uss_shadow_buffer.sv ====
// Shadow receive buffer / transmit holding alias with receive and transmit FIFOs.
// Assumes a character serializer and deserializer outside, and a single-cycle register master.
`timescale 1ns/1ns

// Notes on behaviour
// R1: Reading the low byte of any shadow location returns the received character from the UART or infrared path.
// R2: The received byte is meaningful only while the data-available flag is set.
// R3: Without FIFOs a new character overwrites an unread one and flags overrun.
// R4: With FIFOs a shadow read returns the oldest receive FIFO entry.
// R5: With a full receive FIFO a new character is dropped, the stored data kept, and overrun flagged.
// R6: A byte written to the shadow location goes out on the UART or infrared transmit path.
// R7: Software writes transmit data only while the transmit-holding-empty flag is set.
// R8: Without FIFOs one write clears the transmit-holding-empty flag.
// R9: Without FIFOs further writes before the flag sets again replace the pending character.
// R10: With FIFOs the transmit FIFO takes up to its depth of characters before reporting full.
// R11: A write to a full transmit FIFO is discarded and the contents are unchanged.
// R12: The buffer is aliased over sixteen consecutive word locations, all behaving alike.
// R13: A read through any alias advances the receive FIFO and updates data-available like the primary one.
module uss_shadow_buffer #(
  parameter int unsigned DEPTH = uss_pkg::USS_DEPTH
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [31:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  input wire uss_pkg::uss_char_type rx_uart_char,
  input wire uss_pkg::uss_char_type rx_ir_char,
  output uss_pkg::uss_tx_out_type tx_char,
  input wire logic tx_ready,
  output logic rx_data_available,
  output logic tx_holding_empty,
  output logic irq
);
  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] CAP_FIFO = CW'(DEPTH);
  localparam logic [CW-1:0] CAP_ONE = CW'(1);

  function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
    ptr_inc = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
  endfunction

  function automatic logic is_alias(input logic [31:0] a);
    logic [31:0] off;
    off = a - uss_pkg::USS_ALIAS_BASE;
    is_alias = (a >= uss_pkg::USS_ALIAS_BASE) && (off[1:0] == 2'h0) && (off[31:2] < 30'(uss_pkg::USS_ALIAS_COUNT));
  endfunction

  logic [7:0] rx_mem [DEPTH];
  logic [7:0] tx_mem [DEPTH];
  logic [PW-1:0] rx_rd_ptr_reg, rx_wr_ptr_reg, tx_rd_ptr_reg, tx_wr_ptr_reg;
  logic [CW-1:0] rx_cnt_reg, rx_cnt_next, tx_cnt_reg, tx_cnt_next;
  logic [1:0] ctrl_reg;
  logic overrun_reg;
  logic [3:0] int_status_reg, int_mask_reg, int_event;
  uss_pkg::uss_tx_out_type tx_char_reg;
  logic [31:0] rdata_reg;
  logic irq_reg, rx_avail_reg, tx_empty_reg;

  logic fifo_en, ir_mode, flush;
  logic alias_rd, alias_wr;
  uss_pkg::uss_char_type rx_in;
  logic [CW-1:0] cap;
  logic rx_full, rx_pop, rx_push, rx_overwrite, rx_overrun;
  logic tx_full, tx_load, tx_push, tx_overwrite, tx_lost;
  logic [7:0] rx_head, tx_head;

  assign fifo_en = ctrl_reg[uss_pkg::USS_CTRL_FIFO_EN];
  assign ir_mode = ctrl_reg[uss_pkg::USS_CTRL_IR_MODE];
  // Toggling FIFO mode empties both sides, pointers would be meaningless otherwise
  assign flush = reg_write && (reg_addr == uss_pkg::USS_CTRL) && (reg_wdata[uss_pkg::USS_CTRL_FIFO_EN] != fifo_en);
  assign alias_rd = reg_read && is_alias(reg_addr); // R12 R13
  assign alias_wr = reg_write && is_alias(reg_addr); // R12
  assign rx_in = ir_mode ? rx_ir_char : rx_uart_char; // R1
  assign cap = fifo_en ? CAP_FIFO : CAP_ONE;
  assign rx_head = rx_mem[rx_rd_ptr_reg];
  assign tx_head = tx_mem[tx_rd_ptr_reg];

  // Receive side
  assign rx_full = (rx_cnt_reg == cap);
  assign rx_pop = alias_rd && (rx_cnt_reg != '0); // R13
  assign rx_push = rx_in.valid && (!rx_full || rx_pop);
  assign rx_overwrite = rx_in.valid && rx_full && !rx_pop && !fifo_en; // R3
  assign rx_overrun = rx_in.valid && rx_full && !rx_pop; // R3 R5

  always_comb begin
    rx_cnt_next = rx_cnt_reg;
    if (flush) begin
      rx_cnt_next = '0;
    end else if (rx_push && !rx_pop) begin
      rx_cnt_next = rx_cnt_reg + CW'(1);
    end else if (rx_pop && !rx_push) begin
      rx_cnt_next = rx_cnt_reg - CW'(1);
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      rx_rd_ptr_reg <= '0;
      rx_wr_ptr_reg <= '0;
      rx_cnt_reg <= '0;
    end else begin
      rx_cnt_reg <= rx_cnt_next;
      if (flush) begin
        rx_rd_ptr_reg <= '0;
        rx_wr_ptr_reg <= '0;
      end else begin
        if (rx_pop) begin
          rx_rd_ptr_reg <= ptr_inc(rx_rd_ptr_reg); // R4
        end
        if (rx_push) begin
          rx_wr_ptr_reg <= ptr_inc(rx_wr_ptr_reg);
        end
      end
    end
  end

  // Full FIFO drops the new character: no write at all
  always_ff @(posedge mclk) begin
    if (rx_push && !flush) begin
      rx_mem[rx_wr_ptr_reg] <= rx_in.data;
    end else if (rx_overwrite && !flush) begin
      rx_mem[rx_rd_ptr_reg] <= rx_in.data; // R3
    end
  end

  // Transmit side
  assign tx_full = (tx_cnt_reg == cap);
  assign tx_load = (tx_cnt_reg != '0) && (!tx_char_reg.valid || tx_ready);
  assign tx_push = alias_wr && (!tx_full || tx_load); // R10
  assign tx_overwrite = alias_wr && tx_full && !tx_load && !fifo_en; // R9
  assign tx_lost = alias_wr && tx_full && !tx_load && fifo_en; // R11

  always_comb begin
    tx_cnt_next = tx_cnt_reg;
    if (flush) begin
      tx_cnt_next = '0;
    end else if (tx_push && !tx_load) begin
      tx_cnt_next = tx_cnt_reg + CW'(1); // R8
    end else if (tx_load && !tx_push) begin
      tx_cnt_next = tx_cnt_reg - CW'(1);
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      tx_rd_ptr_reg <= '0;
      tx_wr_ptr_reg <= '0;
      tx_cnt_reg <= '0;
    end else begin
      tx_cnt_reg <= tx_cnt_next;
      if (flush) begin
        tx_rd_ptr_reg <= '0;
        tx_wr_ptr_reg <= '0;
      end else begin
        if (tx_load) begin
          tx_rd_ptr_reg <= ptr_inc(tx_rd_ptr_reg);
        end
        if (tx_push) begin
          tx_wr_ptr_reg <= ptr_inc(tx_wr_ptr_reg);
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (tx_push && !flush) begin
      tx_mem[tx_wr_ptr_reg] <= reg_wdata[7:0]; // R6
    end else if (tx_overwrite && !flush) begin
      tx_mem[tx_rd_ptr_reg] <= reg_wdata[7:0]; // R9
    end
  end

  // Character in flight stays put until the serializer takes it
  always_ff @(posedge mclk) begin
    if (reset) begin
      tx_char_reg <= '0;
    end else if (tx_load && !flush) begin
      tx_char_reg.valid <= 1'b1;
      tx_char_reg.ir <= ir_mode; // R6
      tx_char_reg.data <= tx_head; // R6
    end else if (tx_ready) begin
      tx_char_reg.valid <= 1'b0;
    end
  end

  // Control and mask
  always_ff @(posedge mclk) begin
    if (reset) begin
      ctrl_reg <= uss_pkg::USS_CTRL_RESET;
      int_mask_reg <= uss_pkg::USS_INT_RESET;
    end else if (reg_write) begin
      if (reg_addr == uss_pkg::USS_CTRL) begin
        ctrl_reg <= reg_wdata[1:0];
      end
      if (reg_addr == uss_pkg::USS_INT_MASK) begin
        int_mask_reg <= reg_wdata[3:0];
      end
    end
  end

  // Sticky flags: a new event wins over the clear by read
  assign int_event[uss_pkg::USS_INT_RX] = rx_push;
  assign int_event[uss_pkg::USS_INT_OVERRUN] = rx_overrun;
  assign int_event[uss_pkg::USS_INT_TX_EMPTY] = (tx_cnt_reg != '0) && (tx_cnt_next == '0);
  assign int_event[uss_pkg::USS_INT_TX_LOST] = tx_lost;

  always_ff @(posedge mclk) begin
    if (reset) begin
      overrun_reg <= 1'b0;
      int_status_reg <= uss_pkg::USS_INT_RESET;
    end else begin
      if (rx_overrun) begin
        overrun_reg <= 1'b1; // R3 R5
      end else if (reg_read && reg_addr == uss_pkg::USS_LINE_STATUS) begin
        overrun_reg <= 1'b0;
      end
      if (reg_read && reg_addr == uss_pkg::USS_INT_STATUS) begin
        int_status_reg <= int_event;
      end else begin
        int_status_reg <= int_status_reg | int_event;
      end
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge mclk) begin
    if (reset) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= '0;
      if (reg_read) begin
        if (is_alias(reg_addr)) begin
          rdata_reg <= {24'h0, rx_head}; // R1 R4
        end else begin
          unique case (reg_addr)
            uss_pkg::USS_CTRL: rdata_reg <= {30'h0, ctrl_reg};
            uss_pkg::USS_LINE_STATUS: begin
              rdata_reg[uss_pkg::USS_LS_DATA_AVAIL] <= rx_avail_reg; // R2
              rdata_reg[uss_pkg::USS_LS_OVERRUN] <= overrun_reg;
              rdata_reg[uss_pkg::USS_LS_TX_EMPTY] <= tx_empty_reg; // R7
              rdata_reg[uss_pkg::USS_LS_TX_FULL] <= tx_full;
            end
            uss_pkg::USS_INT_STATUS: rdata_reg <= {28'h0, int_status_reg};
            uss_pkg::USS_INT_MASK: rdata_reg <= {28'h0, int_mask_reg};
            default: rdata_reg <= '0;
          endcase
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      rx_avail_reg <= 1'b0;
      tx_empty_reg <= 1'b1;
      irq_reg <= 1'b0;
    end else begin
      rx_avail_reg <= (rx_cnt_next != '0); // R2 R13
      tx_empty_reg <= (tx_cnt_next == '0); // R8
      irq_reg <= |(int_status_reg & int_mask_reg);
    end
  end

  assign reg_rdata = rdata_reg;
  assign tx_char = tx_char_reg;
  assign rx_data_available = rx_avail_reg;
  assign tx_holding_empty = tx_empty_reg;
  assign irq = irq_reg;

  property p_rx_head;
    @(posedge mclk) disable iff (reset) rx_pop |=> reg_rdata == {24'h0, $past(rx_head)};
  endproperty
  a_rx_head: assert property (p_rx_head) else $error("shadow read did not return head"); // R1

  property p_avail;
    @(posedge mclk) disable iff (reset) rx_in.valid && !flush |=> rx_data_available;
  endproperty
  a_avail: assert property (p_avail) else $error("data available not set after arrival"); // R2

  property p_overwrite;
    @(posedge mclk) disable iff (reset)
      !fifo_en && rx_cnt_reg == CAP_ONE && rx_in.valid && !alias_rd && !flush
      |=> rx_cnt_reg == CAP_ONE && overrun_reg && rx_head == $past(rx_in.data);
  endproperty
  a_overwrite: assert property (p_overwrite) else $error("single buffer overwrite wrong"); // R3

  property p_fifo_advance;
    @(posedge mclk) disable iff (reset) fifo_en && rx_pop && !flush |=> rx_rd_ptr_reg == ptr_inc($past(rx_rd_ptr_reg));
  endproperty
  a_fifo_advance: assert property (p_fifo_advance) else $error("receive head did not advance"); // R4

  property p_rx_drop;
    @(posedge mclk) disable iff (reset)
      fifo_en && rx_full && rx_in.valid && !alias_rd && !flush
      |=> rx_cnt_reg == CAP_FIFO && $stable(rx_wr_ptr_reg) && overrun_reg && int_status_reg[uss_pkg::USS_INT_OVERRUN];
  endproperty
  a_rx_drop: assert property (p_rx_drop) else $error("full receive FIFO lost stored data"); // R5

  property p_tx_hold;
    @(posedge mclk) disable iff (reset) tx_char.valid && !tx_ready |=> tx_char.valid && $stable(tx_char.data);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("transmit character dropped before taken"); // R6

  // An idle serializer may take the byte one cycle later, so only the next cycle is checked
  property p_empty_clear;
    @(posedge mclk) disable iff (reset) !fifo_en && tx_cnt_reg == '0 && alias_wr && !flush |=> !tx_holding_empty;
  endproperty
  a_empty_clear: assert property (p_empty_clear) else $error("holding empty not cleared by write"); // R8

  property p_replace;
    @(posedge mclk) disable iff (reset)
      !fifo_en && tx_cnt_reg == CAP_ONE && alias_wr && !tx_load && !flush |=> tx_head == $past(reg_wdata[7:0]);
  endproperty
  a_replace: assert property (p_replace) else $error("pending character not replaced"); // R9

  property p_tx_full_drop;
    @(posedge mclk) disable iff (reset)
      fifo_en && tx_cnt_reg == CAP_FIFO && alias_wr && !tx_load && !flush
      |=> tx_cnt_reg == CAP_FIFO && $stable(tx_wr_ptr_reg) && int_status_reg[uss_pkg::USS_INT_TX_LOST];
  endproperty
  a_tx_full_drop: assert property (p_tx_full_drop) else $error("write to full FIFO not discarded"); // R10 R11

  property p_tx_accept;
    @(posedge mclk) disable iff (reset)
      fifo_en && !tx_full && alias_wr && !tx_load && !flush |=> tx_cnt_reg == $past(tx_cnt_reg) + CW'(1);
  endproperty
  a_tx_accept: assert property (p_tx_accept) else $error("transmit FIFO refused a write below depth"); // R10

  property p_alias_upper;
    @(posedge mclk) disable iff (reset) alias_rd |=> reg_rdata[31:8] == 24'h0;
  endproperty
  a_alias_upper: assert property (p_alias_upper) else $error("alias read returned upper bits"); // R12

  property p_alias_pop;
    @(posedge mclk) disable iff (reset)
      rx_pop && !rx_in.valid && !flush |=> rx_cnt_reg == $past(rx_cnt_reg) - CW'(1);
  endproperty
  a_alias_pop: assert property (p_alias_pop) else $error("alias read did not advance receive side"); // R12 R13

  c_overrun: cover property (@(posedge mclk) disable iff (reset) fifo_en && rx_overrun);
  c_tx_full: cover property (@(posedge mclk) disable iff (reset) fifo_en && tx_full);
  c_overwrite: cover property (@(posedge mclk) disable iff (reset) tx_overwrite);
  c_rx_overwrite: cover property (@(posedge mclk) disable iff (reset) rx_overwrite);
  c_irq: cover property (@(posedge mclk) disable iff (reset) irq);
endmodule
